// [rtl/swb_top.v]
// apb register block: fifo watermarks, underrun fill word and serial clock divider
`timescale 1ns/1ps
`include "swb_regs.vh"
module swb_top #(
  parameter DEPTH = 32
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [5:0] rx_fill_count,
  input wire [5:0] tx_fill_count,
  input wire tx_underrun_event,
  input wire [31:0] tx_buffer_word,
  output reg [31:0] tx_shift_word_r,
  output wire rx_watermark_event,
  output wire tx_watermark_event,
  output wire tx_underrun_flag,
  output wire serial_unit_enable,
  output wire [4:0] word_length_select,
  output wire sck,
  output wire irq
);
  reg [15:0] wmask_r;
  reg [15:0] ur_lo_r;
  reg [15:0] ur_hi_r;
  reg [15:0] ctrl_r;
  reg [12:0] div_r;
  reg tur_r;
  reg [2:0] irq_st_r;
  reg [2:0] irq_mask_r;
  wire wr;
  wire rd;
  wire [5:0] rx_lvl_impl;
  wire [5:0] tx_lvl_impl;
  wire enh_mode;
  wire underrun_fill_enable;
  wire [2:0] ev;
  wire [2:0] w1c;
  reg [31:0] fill_word;
  reg addr_ok;

  // single-cycle access phase, no wait states
  assign wr = psel & penable & pwrite;
  assign rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign serial_unit_enable = ctrl_r[`SWB_CTRL_EN_BIT];
  assign underrun_fill_enable = ctrl_r[`SWB_CTRL_UNDERRUN_FILL_ENABLE_BIT];
  assign enh_mode = ctrl_r[`SWB_CTRL_ENH_BIT];
  assign word_length_select = ctrl_r[`SWB_CTRL_WLEN_LSB+4:`SWB_CTRL_WLEN_LSB];
  assign tx_underrun_flag = tur_r;

  // address decode
  always @* begin
    case (paddr)
      `SWB_OFS_WMASK, `SWB_OFS_URLO, `SWB_OFS_URHI, `SWB_OFS_CTRL,
      `SWB_OFS_DIV, `SWB_OFS_STAT, `SWB_OFS_IRQ_ST, `SWB_OFS_IRQ_MASK: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // register writes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wmask_r <= `SWB_WMASK_RST;
      ur_lo_r <= `SWB_UR_RST;
      ur_hi_r <= `SWB_UR_RST;
      ctrl_r <= `SWB_CTRL_RST;
      div_r <= `SWB_DIV_RST;
      irq_mask_r <= 3'h0;
    end else if (wr) begin
      case (paddr)
        `SWB_OFS_WMASK: wmask_r <= pwdata[15:0];
        `SWB_OFS_URLO: ur_lo_r <= pwdata[15:0];
        `SWB_OFS_URHI: ur_hi_r <= pwdata[15:0];
        `SWB_OFS_CTRL: ctrl_r <= {3'h0, pwdata[12:8], 5'h00, pwdata[2:0]};
        // divisor writes while enabled are accepted; result then undefined
        `SWB_OFS_DIV: div_r <= pwdata[12:0];
        `SWB_OFS_IRQ_MASK: irq_mask_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // watermark comparators
  swb_wm_cmp #(.DEPTH(DEPTH), .LE_MODE(1)) u_rx_cmp (
    .level(wmask_r[13:8]),
    .fill(rx_fill_count),
    .enable(wmask_r[`SWB_RX_WATERMARK_IRQ_ENABLE_BIT]),
    .valid_mode(enh_mode),
    .level_impl(rx_lvl_impl),
    .event_out(rx_watermark_event)
  );
  swb_wm_cmp #(.DEPTH(DEPTH), .LE_MODE(0)) u_tx_cmp (
    .level(wmask_r[5:0]),
    .fill(tx_fill_count),
    .enable(wmask_r[`SWB_TX_WATERMARK_IRQ_ENABLE_BIT]),
    .valid_mode(enh_mode),
    .level_impl(tx_lvl_impl),
    .event_out(tx_watermark_event)
  );

  // underrun flag set by the event, held until a one is written to stat bit 0, dropped while disabled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tur_r <= 1'b0;
    end else if (!serial_unit_enable) begin
      tur_r <= 1'b0;
    end else if (tx_underrun_event) begin
      tur_r <= 1'b1;
    end else if (wr && paddr == `SWB_OFS_STAT && pwdata[0]) begin
      tur_r <= 1'b0;
    end
  end

  // fill word trimmed to the word length: 0 selects 32 bits
  always @* begin
    fill_word = 32'h0000_0000;
    if (word_length_select == 5'h00 || word_length_select >= 5'h19) begin
      fill_word = {ur_hi_r, ur_lo_r};
    end else if (word_length_select >= 5'h11) begin
      fill_word = {8'h00, ur_hi_r[7:0], ur_lo_r};
    end else if (word_length_select >= 5'h09) begin
      fill_word = {16'h0000, ur_lo_r};
    end else begin
      fill_word = {24'h000000, ur_lo_r[7:0]};
    end
  end

  // word handed to the shifter
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_word_r <= 32'h0000_0000;
    end else if (tx_underrun_event && underrun_fill_enable) begin
      tx_shift_word_r <= fill_word;
    end else begin
      tx_shift_word_r <= tx_buffer_word;
    end
  end

  // serial clock
  swb_baud u_baud (
    .pclk(pclk),
    .presetn(presetn),
    .run(serial_unit_enable),
    .divisor(div_r),
    .sck_r(sck)
  );

  // sticky interrupt status, set beats write-one-to-clear
  assign ev = {tx_underrun_event & serial_unit_enable, tx_watermark_event, rx_watermark_event};
  assign w1c = (wr && paddr == `SWB_OFS_IRQ_ST) ? pwdata[2:0] : 3'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_st_r <= 3'h0;
    end else begin
      irq_st_r <= (irq_st_r & ~w1c) | ev;
    end
  end
  assign irq = |(irq_st_r & irq_mask_r);

  // read data registered at the end of the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `SWB_OFS_WMASK: prdata <= {16'h0000, wmask_r[15], 1'b0, rx_lvl_impl, wmask_r[7], 1'b0, tx_lvl_impl};
        `SWB_OFS_URLO: prdata <= {16'h0000, ur_lo_r};
        `SWB_OFS_URHI: prdata <= {16'h0000, ur_hi_r};
        `SWB_OFS_CTRL: prdata <= {16'h0000, ctrl_r};
        `SWB_OFS_DIV: prdata <= {19'h00000, div_r};
        // fill counts sit above the flag byte so bit 0 stays the w1c underrun flag
        `SWB_OFS_STAT: prdata <= {8'h00, 2'b00, rx_fill_count, 2'b00, tx_fill_count, 7'h00, tur_r};
        `SWB_OFS_IRQ_ST: prdata <= {29'h0, irq_st_r};
        `SWB_OFS_IRQ_MASK: prdata <= {29'h0, irq_mask_r};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// [inc/swb_regs.vh]
// register offsets, field positions and reset values of the watermark/underrun/baud block
// Summary of operation
// - rx watermark event while enabled and rx level <= rx fill count
// - tx watermark event while enabled and tx level equals tx fill count
// - levels above the fifo capacity never produce a watermark match
// - level bit 2 exists from depth 8, bit 3 from 16, bit 4 at 32
// - on tx underrun with fill enable set, shift out the underrun word instead
// - 9-16 bit words use low register fully; 2-8 bit use its low byte
// - 25-32 bit words use high register fully; 17-24 bit use its low byte
// - serial clock is bus clock divided by twice (divisor plus one)
// - fill counts are six-bit occupancy counts, valid in enhanced buffer mode
// - tx underrun flag is cleared whenever the serial unit is disabled
`ifndef SWB_REGS_VH
`define SWB_REGS_VH
`define SWB_OFS_WMASK 12'h000
`define SWB_OFS_URLO 12'h004
`define SWB_OFS_URHI 12'h008
`define SWB_OFS_CTRL 12'h00c
`define SWB_OFS_DIV 12'h010
`define SWB_OFS_STAT 12'h014
`define SWB_OFS_IRQ_ST 12'h018
`define SWB_OFS_IRQ_MASK 12'h01c
`define SWB_RX_WATERMARK_IRQ_ENABLE_BIT 15
`define SWB_TX_WATERMARK_IRQ_ENABLE_BIT 7
`define SWB_CTRL_EN_BIT 0
`define SWB_CTRL_UNDERRUN_FILL_ENABLE_BIT 1
`define SWB_CTRL_ENH_BIT 2
`define SWB_CTRL_WLEN_LSB 8
`define SWB_IRQ_RXW 0
`define SWB_IRQ_TXW 1
`define SWB_IRQ_TUR 2
`define SWB_WMASK_RST 16'h0000
`define SWB_UR_RST 16'h0000
`define SWB_DIV_RST 13'h0000
`define SWB_CTRL_RST 16'h0000
`endif

// [rtl/swb_wm_cmp.v]
// one watermark comparator with level bits trimmed to the fifo capacity
`timescale 1ns/1ps
module swb_wm_cmp #(
  parameter DEPTH = 32,
  parameter LE_MODE = 1
) (
  input wire [5:0] level,
  input wire [5:0] fill,
  input wire enable,
  input wire valid_mode,
  output wire [5:0] level_impl,
  output wire event_out
);
  // unimplemented level bits read as zero
  wire [5:0] keep;
  assign keep = {1'b1, (DEPTH >= 32), (DEPTH >= 16), (DEPTH >= 8), 2'b11};
  assign level_impl = level & keep;
  // out-of-range level never matches
  wire in_range;
  assign in_range = ({26'h0, level_impl} <= DEPTH);
  wire hit;
  assign hit = LE_MODE ? (level_impl <= fill) : (level_impl == fill);
  // purely combinational so it is evaluated every cycle
  assign event_out = enable & valid_mode & in_range & hit;
endmodule

// [rtl/swb_baud.v]
// serial clock divider: toggles every divisor+1 bus clocks
`timescale 1ns/1ps
module swb_baud (
  input wire pclk,
  input wire presetn,
  input wire run,
  input wire [12:0] divisor,
  output reg sck_r
);
  reg [12:0] cnt_r;
  // half period of divisor+1 cycles gives pclk/(2*(div+1))
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 13'h0000;
      sck_r <= 1'b0;
    end else if (!run) begin
      cnt_r <= 13'h0000;
      sck_r <= 1'b0;
    end else if (cnt_r >= divisor) begin
      cnt_r <= 13'h0000;
      sck_r <= ~sck_r;
    end else begin
      cnt_r <= cnt_r + 13'h0001;
    end
  end
endmodule

// [bench/swb_fifo_model.sv]
// far-side fifo and shifter stand-in: occupancy, underrun pulses, buffer words
`timescale 1ns/1ps
module swb_fifo_model (
  input wire pclk,
  input wire [5:0] rx_set,
  input wire [5:0] tx_set,
  input wire ur_req,
  output reg [5:0] rx_fill_count,
  output reg [5:0] tx_fill_count,
  output reg tx_underrun_event,
  output reg [31:0] tx_buffer_word
);
  initial {rx_fill_count, tx_fill_count, tx_underrun_event, tx_buffer_word} = 0;
  // buffer word moves every cycle so a stale copy cannot pass
  always @(posedge pclk) begin
    rx_fill_count <= rx_set;
    tx_fill_count <= tx_set;
    tx_underrun_event <= ur_req;
    tx_buffer_word <= tx_buffer_word + 32'h01010101;
  end
endmodule

// [bench/swb_top_properties.sv]
// port-level assertions for the watermark, underrun and divider block
`timescale 1ns/1ps
module swb_top_chk #(
  parameter DEPTH = 32
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire [5:0] rx_fill_count,
  input wire [5:0] tx_fill_count,
  input wire tx_underrun_event,
  input wire [31:0] tx_buffer_word,
  input wire [31:0] tx_shift_word_r,
  input wire rx_watermark_event,
  input wire tx_watermark_event,
  input wire tx_underrun_flag,
  input wire serial_unit_enable,
  input wire sck
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // no register write landed at the last edge
  sequence s_quiet;
    !$past(psel);
  endsequence
  a_rx_grow_holds: assert property (s_quiet ##0 ($past(rx_watermark_event) && rx_fill_count >= $past(rx_fill_count))
    |-> rx_watermark_event) else $error("rx mark lost");
  a_tx_exact_only: assert property (s_quiet ##0 ($past(tx_watermark_event) && tx_fill_count != $past(tx_fill_count))
    |-> !tx_watermark_event) else $error("tx mark held");
  a_tx_in_depth: assert property (tx_watermark_event |-> tx_fill_count <= DEPTH)
    else $error("tx mark too deep");
  a_rx_steady: assert property (s_quiet ##0 $stable(rx_fill_count) |-> $stable(rx_watermark_event))
    else $error("rx mark moved");
  a_tx_steady: assert property (s_quiet ##0 $stable(tx_fill_count) |-> $stable(tx_watermark_event))
    else $error("tx mark moved");
  a_shift_buffer: assert property (!tx_underrun_event |=> tx_shift_word_r == $past(tx_buffer_word))
    else $error("buffer word lost");
  a_flag_cleared: assert property (!serial_unit_enable [*2] |-> !tx_underrun_flag)
    else $error("flag while off");
  a_sck_parked: assert property (!serial_unit_enable [*2] |-> !sck)
    else $error("sck while off");
endmodule
bind swb_top swb_top_chk #(.DEPTH(DEPTH)) u_chk (.*);

// [bench/swb_top_bench.sv]
// apb bench for the watermark, underrun and divider block
`timescale 1ns/1ps
module swb_top_bench;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, ur_req = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, rd_v, msk;
  reg [5:0] rx_set = 0, tx_set = 0;
  wire [31:0] prdata, tx_buffer_word, tx_shift_word_r;
  wire [5:0] rx_fill_count, tx_fill_count;
  wire [4:0] word_length_select;
  wire pready, tx_underrun_event, rx_watermark_event, tx_watermark_event;
  wire tx_underrun_flag, serial_unit_enable, sck, irq, pslverr;
  reg err_v;
  integer n_errors = 0, total_checks = 0, cyc = 0, i, t0;
  always #5 pclk = ~pclk;
  swb_fifo_model u_swb_fifo_model (.*);
  swb_top u_swb_top (.*);
  task conclude;
    begin
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  // hang guard, the run needs well under a thousand cycles
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_errors = n_errors + 1;
      conclude;
    end
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      @(posedge pclk);
      while (!pready) @(posedge pclk);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 0;
      penable <= 0;
      #1;
    end
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    begin
      apb(0, a, 0);
      chk(rd_v, e);
    end
  endtask
  task fills(input [5:0] r, input [5:0] t);
    begin
      @(posedge pclk);
      rx_set <= r;
      tx_set <= t;
      repeat (2) @(posedge pclk);
      #1;
    end
  endtask
  // one-cycle underrun; the shift word is captured one edge later
  task under;
    begin
      @(posedge pclk);
      ur_req <= 1;
      @(posedge pclk);
      ur_req <= 0;
      @(posedge pclk);
      #1;
    end
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    rdc(12'h000, 0);
    rdc(12'h004, 0);
    apb(1, 12'h004, 32'h0000a5c3);
    apb(1, 12'h008, 32'h00005a3c);
    rdc(12'h004, 32'h0000a5c3);
    rdc(12'h008, 32'h00005a3c);
    chk(err_v, 0);
    rdc(12'h024, 0);
    chk(err_v, 1);
    $display("test regs done");
    // rx level 5, tx level 3, enhanced mode, tx watermark irq unmasked
    apb(1, 12'h00c, 32'h4);
    apb(1, 12'h000, 32'h8583);
    apb(1, 12'h01c, 32'h2);
    for (i = 0; i < 6; i = i + 1) begin
      fills(i + 2, i + 1);
      chk(rx_watermark_event, i + 2 >= 5);
      chk(tx_watermark_event, i + 1 == 3);
    end
    chk(irq, 1);
    rdc(12'h018, 3);
    apb(1, 12'h01c, 0);
    chk(irq, 0);
    apb(1, 12'h018, 7);
    rdc(12'h018, 1);
    // tx enabled at level 33, rx disabled with level 0 below the fill
    apb(1, 12'h000, 32'h00a1);
    fills(33, 33);
    chk(tx_watermark_event, 0);
    chk(rx_watermark_event, 0);
    // rx enabled at level 33 with fill 33: would match if the range check were missing
    apb(1, 12'h000, 32'ha100);
    chk(rx_watermark_event, 0);
    apb(1, 12'h000, 32'h00a0);
    fills(32, 32);
    chk(tx_watermark_event, 1);
    $display("test marks done");
    // fill word per word length 8, 16, 24 and 0 for 32
    for (i = 0; i < 4; i = i + 1) begin
      msk = i == 3 ? 32'hffffffff : (32'h1 << (i * 8 + 8)) - 1;
      apb(1, 12'h00c, ((i * 8 + 8) % 32) * 256 + 3);
      under;
      chk(word_length_select, (i * 8 + 8) % 32);
      chk(tx_shift_word_r, 32'h5a3ca5c3 & msk);
    end
    apb(1, 12'h00c, 1);
    under;
    chk(tx_shift_word_r, tx_buffer_word - 32'h01010101);
    chk(tx_underrun_flag, 1);
    apb(1, 12'h014, 1);
    chk(tx_underrun_flag, 0);
    rdc(12'h014, 32'h00202000);
    rdc(12'h018, 7);
    under;
    chk(tx_underrun_flag, 1);
    apb(1, 12'h00c, 0);
    // flag drops one edge after the enable bit is seen low
    @(posedge pclk);
    #1;
    chk(serial_unit_enable, 0);
    chk(tx_underrun_flag, 0);
    $display("test underrun done");
    apb(1, 12'h010, 3);
    apb(1, 12'h00c, 1);
    @(posedge sck);
    t0 = $time;
    @(posedge sck);
    chk(($time - t0) / 10, 8);
    $display("test divider done");
    conclude;
  end
endmodule
